// ### lft_debounce.sv
// debouncer for the active-low toggle input
// assumes the input is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module lft_debounce #(
	parameter int DEB_CYCLES = lft_pkg::DEB_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic raw_n,
	output logic settled_n,
	output logic press
);
	import lft_pkg::*;

	logic sample_r;
	logic settled_r;
	logic press_r;
	logic [DEB_CNT_W-1:0] cnt_r;

	assign settled_n = settled_r;
	assign press = press_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_r <= 1'b1;
		end else begin
			sample_r <= raw_n;
		end
	end

	// level must hold a full interval either way before it settles
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			settled_r <= 1'b1;
			press_r <= 1'b0;
			cnt_r <= '0;
		end else begin
			press_r <= 1'b0;
			if (sample_r == settled_r) begin
				cnt_r <= '0;
			end else if (cnt_r == DEB_CNT_W'(DEB_CYCLES - 1)) begin
				settled_r <= sample_r;
				press_r <= settled_r;
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule : lft_debounce
`default_nettype wire

// ### lft_led_fade_ctrl.sv
// top of the led toggle/fade controller: debounced toggle, step timer,
// ramp sequencer and gamma lookup driving a current code
// assumes a 100 MHz clock; the analog stage turns the code into current
//
// Overview of operation
// - after reset the channel is off with zero current until a press
// - debounced press while off turns channel on and ramps up from zero
// - debounced press while sourcing ramps current down towards zero
// - presses are accepted while a fade is still in progress
// - toggle input debounced with a typical 37 ms interval
// - debounce applies to both falling and rising edges
// - each ramp moves through 63 gamma-corrected steps
// - total fade time is fade resistor ohms times 2.5 us
// - grounded fade pin ramps in about 73 us, debounce kept
// - gamma table starts 0,2,4,6,8,10,12,16 and reaches 318 at 39
// - input must be stable for the interval, 25 to 50 ms
// - gamma indices 40 to 47 hold 336 up to 482
`timescale 1ns/1ps
`default_nettype none
module lft_led_fade_ctrl #(
	parameter int DEB_CYCLES = lft_pkg::DEB_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic toggle_n,
	input wire logic fade_time_pin_grounded,
	input wire logic [lft_pkg::RES_W-1:0] fade_resistor,
	output logic [lft_pkg::CODE_W-1:0] current_code,
	output logic channel_on,
	output logic fading,
	output logic toggle_settled_n
);
	import lft_pkg::*;

	logic press;
	logic settled_n;
	logic step_tick;
	logic ramping;
	lft_state_type state_r;
	logic [IDX_W-1:0] idx_r;
	logic [CODE_W-1:0] code_r;
	logic on_r;
	logic fading_r;
	logic settled_r;

	lft_debounce #(
		.DEB_CYCLES(DEB_CYCLES)
	) u_debounce (
		.clk(clk),
		.rst_n(rst_n),
		.raw_n(toggle_n),
		.settled_n(settled_n),
		.press(press)
	);

	assign ramping = (state_r == LFT_RAMP_UP) || (state_r == LFT_RAMP_DOWN);

	lft_step_timer u_step_timer (
		.clk(clk),
		.rst_n(rst_n),
		.run(ramping),
		.restart(press),
		.fast(fade_time_pin_grounded),
		.fade_resistor(fade_resistor),
		.step_tick(step_tick)
	);

	// sequencer: presses win over step ticks in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= LFT_OFF;
		end else if (press) begin
			case (state_r)
				LFT_OFF: state_r <= LFT_RAMP_UP;
				LFT_RAMP_UP: state_r <= LFT_RAMP_DOWN;
				LFT_ON: state_r <= LFT_RAMP_DOWN;
				LFT_RAMP_DOWN: state_r <= LFT_RAMP_UP;
				default: state_r <= LFT_OFF;
			endcase
		end else if (step_tick) begin
			case (state_r)
				LFT_RAMP_UP: begin
					if (idx_r == IDX_MAX) begin
						state_r <= LFT_ON;
					end
				end
				LFT_RAMP_DOWN: begin
					if (idx_r == IDX_MIN) begin
						state_r <= LFT_OFF;
					end
				end
				LFT_OFF: state_r <= LFT_OFF;
				LFT_ON: state_r <= LFT_ON;
				default: state_r <= LFT_OFF;
			endcase
		end
	end

	// index keeps its place on reversal; one step per tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idx_r <= IDX_MIN;
		end else if (!press && step_tick) begin
			if (state_r == LFT_RAMP_UP && idx_r != IDX_MAX) begin
				idx_r <= idx_r + 1'b1;
			end else if (state_r == LFT_RAMP_DOWN && idx_r != IDX_MIN) begin
				idx_r <= idx_r - 1'b1;
			end
		end
	end

	// output code: zero once fully off, table value otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			code_r <= CODE_OFF;
		end else if (state_r == LFT_OFF) begin
			code_r <= CODE_OFF;
		end else begin
			code_r <= GAMMA_TABLE[idx_r];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			on_r <= 1'b0;
			fading_r <= 1'b0;
			settled_r <= 1'b1;
		end else begin
			on_r <= (state_r != LFT_OFF);
			fading_r <= ramping;
			settled_r <= settled_n;
		end
	end

	assign current_code = code_r;
	assign channel_on = on_r;
	assign fading = fading_r;
	assign toggle_settled_n = settled_r;
endmodule : lft_led_fade_ctrl
`default_nettype wire

// ### lft_led_fade_ctrl_test.sv
// self-checking bench for lft_led_fade_ctrl
// assumes lft_switch_model drives the toggle line
`timescale 1ns/1ps
`default_nettype none
module lft_led_fade_ctrl_test;
	import lft_pkg::*;
	localparam int DEB = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fast = 1'b1;
	// 2 ohm keeps runs short, far below the advised range
	logic [RES_W-1:0] res = 24'h000002;
	logic [CODE_W-1:0] code;
	logic on, fad, setl_n, tog_n;
	logic [CODE_W-1:0] seen [$];
	int fail_count = 0;
	int checks_done = 0;
	int n;
	lft_switch_model sw (.clk(clk), .toggle_n(tog_n));
	lft_led_fade_ctrl #(.DEB_CYCLES(DEB)) dut (.clk(clk), .rst_n(rst_n),
		.toggle_n(tog_n), .fade_time_pin_grounded(fast),
		.fade_resistor(res), .current_code(code), .channel_on(on),
		.fading(fad), .toggle_settled_n(setl_n));
	initial forever #5 clk = ~clk;
	task automatic check(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// press and hold, log each new code until the ramp stops, release
	task automatic ramp();
		n = 0;
		sw.set_level(1'b0, 3);
		for (int i = 0; i < 60 && fad !== 1'b1; i++) @(negedge clk);
		seen = {code};
		while (fad === 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
			if (code !== seen[$]) seen.push_back(code);
		end
		sw.set_level(1'b1, 3);
		repeat (DEB + 10) @(negedge clk);
	endtask : ramp
	task automatic t_reset_glitch();
		check("code", 0, code);
		check("on", 0, on);
		check("fading", 0, fad);
		check("settled", 1, setl_n);
		sw.set_level(1'b0, 0);
		repeat (DEB - 4) @(negedge clk);
		sw.set_level(1'b1, 0);
		repeat (2 * DEB) @(negedge clk);
		check("glitch on", 0, on);
		check("glitch settled", 1, setl_n);
		$display("reset and glitch test done");
	endtask : t_reset_glitch
	task automatic t_fast();
		ramp();
		check("up steps", 63, seen.size());
		check("code 7", 16, seen[7]);
		check("code 39", 318, seen[39]);
		check("code 40", 336, seen[40]);
		check("code 47", 482, seen[47]);
		check("up top", 10'h3FF, seen[62]);
		check("fast time", 1, n > 7125 && n < 7365);
		check("on", 1, on);
		ramp();
		check("down steps", 63, seen.size());
		check("down code 7", 16, seen[55]);
		check("down end", 0, seen[62]);
		check("off", 0, on);
		$display("fast ramp test done");
	endtask : t_fast
	task automatic t_reverse();
		logic [CODE_W-1:0] top;
		sw.set_level(1'b0, 3);
		for (int i = 0; i < 3000 && code < 10'h030; i++) @(negedge clk);
		sw.set_level(1'b1, 3);
		repeat (DEB + 10) @(negedge clk);
		sw.set_level(1'b0, 3);
		repeat (DEB + 10) @(negedge clk);
		check("settled low", 0, setl_n);
		top = code;
		for (int i = 0; i < 300 && code === top; i++) @(negedge clk);
		check("reversed", 1, code < top && code > 0);
		check("still fading", 1, fad);
		// second reversal: falling ramp turns back up from its index
		sw.set_level(1'b1, 3);
		repeat (DEB + 10) @(negedge clk);
		sw.set_level(1'b0, 3);
		repeat (DEB + 10) @(negedge clk);
		top = code;
		for (int i = 0; i < 300 && code === top; i++) @(negedge clk);
		check("back up", 1, code > top);
		sw.set_level(1'b1, 3);
		repeat (DEB + 10) @(negedge clk);
		sw.set_level(1'b0, 3);
		for (int i = 0; i < 8000 && on !== 1'b0; i++) @(negedge clk);
		check("rev off", 0, on);
		sw.set_level(1'b1, 3);
		repeat (DEB + 10) @(negedge clk);
		$display("reverse test done");
	endtask : t_reverse
	task automatic t_resistor();
		@(posedge clk);
		fast <= 1'b0;
		ramp();
		check("slow up time", 1, n > 460 && n < 540);
		check("slow top", 10'h3FF, code);
		ramp();
		check("slow down time", 1, n > 460 && n < 540);
		$display("resistor fade test done");
	endtask : t_resistor
	// zero ohm on the fade input behaves like the grounded pin
	task automatic t_zero_ohm();
		@(posedge clk);
		res <= 24'h000000;
		ramp();
		check("zero ohm steps", 63, seen.size());
		check("zero ohm time", 1, n > 7125 && n < 7365);
		check("zero ohm top", 10'h3FF, code);
		@(posedge clk);
		res <= 24'h000002;
		ramp();
		check("zero ohm off", 0, on);
		$display("zero ohm fade test done");
	endtask : t_zero_ohm
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		$display("Error watchdog expected 0 seen 1");
		finish_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		t_reset_glitch();
		t_fast();
		t_reverse();
		t_resistor();
		t_zero_ohm();
		finish_test();
	end
endmodule : lft_led_fade_ctrl_test
`default_nettype wire

// ### lft_monitor.sv
// port assertions for lft_led_fade_ctrl
// assumes bind to the top module, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module lft_monitor #(parameter int DEB_CYCLES = 20) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic toggle_n,
	input wire logic [lft_pkg::CODE_W-1:0] current_code,
	input wire logic channel_on,
	input wire logic fading,
	input wire logic toggle_settled_n
);
	import lft_pkg::*;
	logic prev_r;
	int stab_r;
	// cycles the raw toggle line has held its level
	always_ff @(posedge clk) begin
		prev_r <= rst_n ? toggle_n : 1'b1;
		stab_r <= (!rst_n || toggle_n != prev_r) ? 0 : stab_r + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_reset_off: assert property (disable iff (1'b0) !rst_n |=>
		current_code == 10'h000 && !channel_on && !fading)
		else $error("outputs not off after reset");
	chk_settle_wait: assert property ($changed(toggle_settled_n) |->
		stab_r >= DEB_CYCLES + 1) else $error("settled too early");
	chk_settle_due: assert property (stab_r == DEB_CYCLES + 1 |->
		toggle_settled_n == toggle_n) else $error("settle missed");
	chk_press_on: assert property ($fell(toggle_settled_n) && !channel_on
		|-> ##[1:4] channel_on && fading) else $error("no ramp up");
	chk_press_down: assert property ($fell(toggle_settled_n) &&
		channel_on && !fading |-> ##[1:4] fading) else $error("no ramp down");
	chk_code_still: assert property ($changed(current_code) |->
		fading || $past(fading)) else $error("code moved outside ramp");
	chk_full_hold: assert property (channel_on && !fading &&
		$past(channel_on) && !$past(fading) |-> current_code == 10'h3FF)
		else $error("steady on not full");
	chk_off_zero: assert property (!channel_on && !$past(channel_on)
		|-> current_code == 10'h000) else $error("current while off");
endmodule : lft_monitor
bind lft_led_fade_ctrl lft_monitor #(.DEB_CYCLES(DEB_CYCLES)) u_mon (
	.clk(clk), .rst_n(rst_n), .toggle_n(toggle_n),
	.current_code(current_code), .channel_on(channel_on),
	.fading(fading), .toggle_settled_n(toggle_settled_n));
`default_nettype wire

// ### lft_pkg.sv
// constants shared by the led toggle/fade controller and its helpers
// assumes a single 100 MHz clock and a synchronous toggle input
package lft_pkg;
	localparam int CLK_NS = 10;
	// debounce interval, typical figure
	localparam int DEB_MS = 37;
	localparam int DEB_CYC = DEB_MS * 1000000 / CLK_NS;
	localparam int DEB_CNT_W = 32;
	// fade time per ohm of fade resistor: 2.5 us
	localparam int FADE_NS_PER_OHM_X10 = 25000;
	localparam int FADE_CYC_PER_OHM = FADE_NS_PER_OHM_X10 / 10 / CLK_NS;
	// grounded fade pin: whole ramp in about 73 us
	localparam int FAST_FADE_NS = 73000;
	localparam int NUM_STEPS = 63;
	localparam int FAST_STEP_CYC = FAST_FADE_NS / CLK_NS / NUM_STEPS;
	localparam int RES_W = 24;
	localparam int ACC_W = 34;
	localparam int IDX_W = 6;
	localparam int CODE_W = 10;
	localparam logic [IDX_W-1:0] IDX_MIN = 6'h00;
	localparam logic [IDX_W-1:0] IDX_MAX = 6'h3E;
	localparam logic [CODE_W-1:0] CODE_OFF = 10'h000;
	localparam logic [ACC_W-1:0] ACC_STEP = 34'h00000003F;
	localparam logic [ACC_W-1:0] ACC_FAST =
		ACC_W'(FAST_STEP_CYC * NUM_STEPS);
	localparam logic [ACC_W-1:0] ACC_PER_OHM = ACC_W'(FADE_CYC_PER_OHM);

	// gamma codes; last entry stands for full programmed current
	localparam logic [CODE_W-1:0] GAMMA_TABLE [0:NUM_STEPS-1] = '{
		10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00A, 10'h00C,
		10'h010, 10'h014, 10'h018, 10'h01C, 10'h020, 10'h024, 10'h02A,
		10'h030, 10'h036, 10'h03C, 10'h042, 10'h048, 10'h050, 10'h058,
		10'h060, 10'h068, 10'h070, 10'h078, 10'h082, 10'h08C, 10'h096,
		10'h0A0, 10'h0AA, 10'h0B4, 10'h0C2, 10'h0D0, 10'h0DE, 10'h0EC,
		10'h0FA, 10'h108, 10'h11A, 10'h12C, 10'h13E, 10'h150, 10'h162,
		10'h174, 10'h18A, 10'h1A0, 10'h1B6, 10'h1CC, 10'h1E2, 10'h1FC,
		10'h216, 10'h232, 10'h24E, 10'h26C, 10'h28A, 10'h2AA, 10'h2CC,
		10'h2EE, 10'h312, 10'h336, 10'h35C, 10'h384, 10'h3B0, 10'h3FF
	};

	typedef enum logic [3:0] {
		LFT_OFF = 4'h1,
		LFT_RAMP_UP = 4'h2,
		LFT_ON = 4'h4,
		LFT_RAMP_DOWN = 4'h8
	} lft_state_type;
endpackage : lft_pkg

// ### lft_step_timer.sv
// step period generator: spreads the fade time over the 63 steps
// assumes fade_resistor is a static value in ohms
`timescale 1ns/1ps
`default_nettype none
module lft_step_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic restart,
	input wire logic fast,
	input wire logic [lft_pkg::RES_W-1:0] fade_resistor,
	output logic step_tick
);
	import lft_pkg::*;

	logic [ACC_W-1:0] thr;
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic tick_r;

	// threshold is whole fade time in cycles; accumulator adds steps
	always_comb begin
		if (fast || fade_resistor == '0) begin
			thr = ACC_FAST;
		end else begin
			thr = ACC_W'(ACC_PER_OHM * ACC_W'(fade_resistor));
		end
		acc_nxt = acc_r + ACC_STEP;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_r <= '0;
			tick_r <= 1'b0;
		end else if (!run || restart) begin
			acc_r <= '0;
			tick_r <= 1'b0;
		end else if (acc_nxt >= thr) begin
			acc_r <= acc_nxt - thr;
			tick_r <= 1'b1;
		end else begin
			acc_r <= acc_nxt;
			tick_r <= 1'b0;
		end
	end

	assign step_tick = tick_r;
endmodule : lft_step_timer
`default_nettype wire

// ### lft_switch_model.sv
// momentary switch with contact bounce on the active-low toggle line
// assumes clk is the block clock; line idles high through a pull-up
`timescale 1ns/1ps
`default_nettype none
module lft_switch_model (
	output logic toggle_n,
	input wire logic clk
);
	initial toggle_n = 1'b1;
	// bounce in two-cycle chatter, then settle at lvl
	task automatic set_level(input logic lvl, input int bounces);
		for (int i = 0; i < 2 * bounces; i++) begin
			@(posedge clk);
			toggle_n <= i[0] ? ~lvl : lvl;
		end
		@(posedge clk);
		toggle_n <= lvl;
	endtask : set_level
endmodule : lft_switch_model
`default_nettype wire
